/* File: rtl/mdmac_unit.sv */
// multiply, multiply-accumulate and divide unit with its register file
//
// How it works
// - multiply forms 32-bit product of two 16-bit operands, signed or unsigned.
// - accumulate mode adds the 32-bit product to the 32-bit accumulator.
// - divide mode divides 32-bit unsigned by 32-bit, giving quotient and remainder.
// - reset clears all six 16-bit data registers to zero.
// - host writes data registers as whole 16-bit words; a result landing in the same cycle wins over the write.
// - multiplier comes from operand A high, multiplicand from operand A low.
// - dividend read from operand A pair; quotient written back there.
// - product goes to operand B pair, high word bits 31 to 16.
// - divisor is taken from the operand B pair, high register high.
// - accumulator pair holds sum in accumulate mode, remainder in divide mode.
// - accumulate writes sum to accumulator pair and product to operand B.
// - signed modes use two's complement for operands, product and sum.
// - three mode bits select operation; other encodings are prohibited.
// - start bit begins division and clears itself at end unless written as a product lands; software cannot clear.
// - multiply starts when both operand A halves written; ready one clock later.
// - overflow flag set when accumulated value leaves its range.
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/10ps
module mdmac_unit
  import mdmac_pkg::*;
(
  clk_sys,
  resetn,
  reg_addr,
  reg_wdata,
  reg_write,
  reg_read,
  reg_rdata,
  divide_done_irq,
  mode_prohibited
);
  input wire logic clk_sys;
  input wire logic resetn;
  input wire logic [3:0] reg_addr;
  input wire logic [15:0] reg_wdata;
  input wire logic reg_write;
  input wire logic reg_read;
  output logic [15:0] reg_rdata;
  output logic divide_done_irq;
  output logic mode_prohibited;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [1:0] {
    MDMAC_SEQ_IDLE,
    MDMAC_SEQ_MUL,
    MDMAC_SEQ_DIV
  } mdmac_seq_type;

  typedef struct packed {
    logic [15:0] operand_a_low;
    logic [15:0] operand_a_high;
    logic [15:0] operand_b_low;
    logic [15:0] operand_b_high;
    logic [15:0] accumulator_low;
    logic [15:0] accumulator_high;
    logic divide_select;
    logic accumulate_select;
    logic signed_select;
    logic accum_overflow_flag;
    logic accum_sign_flag;
    logic divide_start_busy;
    logic a_low_written;
    logic a_high_written;
    mdmac_seq_type seq;
    logic irq;
    logic [15:0] rdata;
  } mdmac_state_type;

  mdmac_state_type state_reg;
  mdmac_state_type state_next;

  mdmac_mode_type mode;
  logic mul_start;
  logic div_start;
  logic div_done;
  logic [31:0] product;
  logic [31:0] quotient;
  logic [31:0] remainder;
  logic [31:0] accum;
  logic [32:0] usum;
  logic [31:0] ssum;
  logic wr_ctrl;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // read-back image of the control register
  function automatic logic [15:0] ctrl_image(input mdmac_state_type s);
    logic [15:0] v;
    v = 16'h0000;
    v[MDMAC_BIT_DIV] = s.divide_select;
    v[MDMAC_BIT_MAC] = s.accumulate_select;
    v[MDMAC_BIT_SIGNED] = s.signed_select;
    v[MDMAC_BIT_OVF] = s.accum_overflow_flag;
    v[MDMAC_BIT_SIGNF] = s.accum_sign_flag;
    v[MDMAC_BIT_START] = s.divide_start_busy;
    return v;
  endfunction

  // ----------------------------------------
  // mode decode and start conditions
  // ----------------------------------------
  always_comb
  begin
    mode = mdmac_decode({state_reg.divide_select, state_reg.accumulate_select,
                         state_reg.signed_select});
    wr_ctrl = reg_write && (reg_addr == MDMAC_ADDR_CTRL);
    // start the product once both halves are fresh; order of writes is free
    mul_start = (state_reg.seq == MDMAC_SEQ_IDLE) && !state_reg.divide_select
                && state_reg.a_low_written && state_reg.a_high_written
                && (mode != MDMAC_MODE_BAD);
    // start bit only accepted when divide mode is selected in the same write
    div_start = wr_ctrl && reg_wdata[MDMAC_BIT_DIV] && reg_wdata[MDMAC_BIT_START]
                && !reg_wdata[MDMAC_BIT_SIGNED]
                && !state_reg.divide_start_busy;
  end

  // ----------------------------------------
  // datapath instances
  // ----------------------------------------
  mdmac_mul u_mul (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .start(mul_start),
    .signed_mode(state_reg.signed_select),
    .multiplier(state_reg.operand_a_high),
    .multiplicand(state_reg.operand_a_low),
    .product(product)
  );

  mdmac_div u_div (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .start(div_start),
    .dividend({state_reg.operand_a_high, state_reg.operand_a_low}),
    .divisor({state_reg.operand_b_high, state_reg.operand_b_low}),
    .done(div_done),
    .quotient(quotient),
    .remainder(remainder)
  );

  // ----------------------------------------
  // accumulation arithmetic
  // ----------------------------------------
  // both sums built in parallel; the mode picks which one lands
  always_comb
  begin
    accum = {state_reg.accumulator_high, state_reg.accumulator_low};
    usum = {1'b0, accum} + {1'b0, product};
    ssum = accum + product;
  end

  // ----------------------------------------
  // next-state logic: bus writes, sequencing, results
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;
    state_next.irq = 1'b0;
    state_next.rdata = 16'h0000;

    // host writes take effect on the next edge; whole words only
    if (reg_write)
    begin
      case (reg_addr)
        MDMAC_ADDR_A_LOW:
        begin
          state_next.operand_a_low = reg_wdata;
          state_next.a_low_written = 1'b1;
        end
        MDMAC_ADDR_A_HIGH:
        begin
          state_next.operand_a_high = reg_wdata;
          state_next.a_high_written = 1'b1;
        end
        MDMAC_ADDR_B_LOW: state_next.operand_b_low = reg_wdata;
        MDMAC_ADDR_B_HIGH: state_next.operand_b_high = reg_wdata;
        MDMAC_ADDR_C_LOW: state_next.accumulator_low = reg_wdata;
        MDMAC_ADDR_C_HIGH: state_next.accumulator_high = reg_wdata;
        MDMAC_ADDR_CTRL:
        begin
          // mode bits are frozen while a division runs
          if (!state_reg.divide_start_busy)
          begin
            state_next.divide_select = reg_wdata[MDMAC_BIT_DIV];
            state_next.accumulate_select = reg_wdata[MDMAC_BIT_MAC];
            state_next.signed_select = reg_wdata[MDMAC_BIT_SIGNED];
          end
          if (div_start)
          begin
            state_next.divide_start_busy = 1'b1;
          end
        end
        default:
        begin
        end
      endcase
    end

    // sequencing of the two operation kinds
    case (state_reg.seq)
      MDMAC_SEQ_IDLE:
      begin
        // a division wins; a multiply due in the same cycle is dropped, never half-run
        if (div_start)
        begin
          state_next.seq = MDMAC_SEQ_DIV;
        end
        else if (mul_start)
        begin
          state_next.seq = MDMAC_SEQ_MUL;
          // a half written in this very cycle stays fresh for the next product
          state_next.a_low_written = reg_write && (reg_addr == MDMAC_ADDR_A_LOW);
          state_next.a_high_written = reg_write && (reg_addr == MDMAC_ADDR_A_HIGH);
        end
      end
      MDMAC_SEQ_MUL:
      begin
        // product stands one clock after the start
        state_next.operand_b_high = product[31:16];
        state_next.operand_b_low = product[15:0];
        if (state_reg.accumulate_select)
        begin
          if (state_reg.signed_select)
          begin
            state_next.accumulator_high = ssum[31:16];
            state_next.accumulator_low = ssum[15:0];
            state_next.accum_sign_flag = ssum[31];
            if ((accum[31] == product[31]) && (ssum[31] != accum[31]))
            begin
              state_next.accum_overflow_flag = 1'b1;
            end
          end
          else
          begin
            state_next.accumulator_high = usum[31:16];
            state_next.accumulator_low = usum[15:0];
            state_next.accum_sign_flag = 1'b0;
            if (usum[32])
            begin
              state_next.accum_overflow_flag = 1'b1;
            end
          end
        end
        state_next.seq = MDMAC_SEQ_IDLE;
      end
      MDMAC_SEQ_DIV:
      begin
        // quotient and remainder land together with the busy drop
        if (div_done)
        begin
          state_next.operand_a_high = quotient[31:16];
          state_next.operand_a_low = quotient[15:0];
          state_next.accumulator_high = remainder[31:16];
          state_next.accumulator_low = remainder[15:0];
          state_next.divide_start_busy = 1'b0;
          state_next.irq = !state_reg.accumulate_select;
          state_next.a_low_written = reg_write && (reg_addr == MDMAC_ADDR_A_LOW);
          state_next.a_high_written = reg_write && (reg_addr == MDMAC_ADDR_A_HIGH);
          state_next.seq = MDMAC_SEQ_IDLE;
        end
      end
      default:
      begin
        state_next.seq = MDMAC_SEQ_IDLE;
      end
    endcase

    // read data stand in the cycle after the strobe; a data register result landing at the
    // strobe's edge is returned at once, so a product reads one clock after start
    if (reg_read)
    begin
      case (reg_addr)
        MDMAC_ADDR_A_LOW: state_next.rdata = state_next.operand_a_low;
        MDMAC_ADDR_A_HIGH: state_next.rdata = state_next.operand_a_high;
        MDMAC_ADDR_B_LOW: state_next.rdata = state_next.operand_b_low;
        MDMAC_ADDR_B_HIGH: state_next.rdata = state_next.operand_b_high;
        MDMAC_ADDR_C_LOW: state_next.rdata = state_next.accumulator_low;
        MDMAC_ADDR_C_HIGH: state_next.rdata = state_next.accumulator_high;
        MDMAC_ADDR_CTRL: state_next.rdata = ctrl_image(state_reg);
        default: state_next.rdata = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // all data registers clear to zero on reset
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= '0;
      state_reg.operand_a_low <= MDMAC_DATA_RESET;
      state_reg.operand_a_high <= MDMAC_DATA_RESET;
      state_reg.operand_b_low <= MDMAC_DATA_RESET;
      state_reg.operand_b_high <= MDMAC_DATA_RESET;
      state_reg.accumulator_low <= MDMAC_DATA_RESET;
      state_reg.accumulator_high <= MDMAC_DATA_RESET;
      state_reg.seq <= MDMAC_SEQ_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata = state_reg.rdata;
  assign divide_done_irq = state_reg.irq;
  assign mode_prohibited = (mode == MDMAC_MODE_BAD);
endmodule

/* File: common/mdmac_pkg.sv */
// package of constants and types for the multiply/divide/accumulate unit
package mdmac_pkg;

  // ----------------------------------------
  // register map (word index on the plain port)
  // ----------------------------------------
  localparam logic [3:0] MDMAC_ADDR_A_LOW = 4'h0;
  localparam logic [3:0] MDMAC_ADDR_A_HIGH = 4'h1;
  localparam logic [3:0] MDMAC_ADDR_B_LOW = 4'h2;
  localparam logic [3:0] MDMAC_ADDR_B_HIGH = 4'h3;
  localparam logic [3:0] MDMAC_ADDR_C_LOW = 4'h4;
  localparam logic [3:0] MDMAC_ADDR_C_HIGH = 4'h5;
  localparam logic [3:0] MDMAC_ADDR_CTRL = 4'h6;

  // ----------------------------------------
  // control register fields and reset values
  // ----------------------------------------
  localparam int MDMAC_BIT_DIV = 7;
  localparam int MDMAC_BIT_MAC = 6;
  localparam int MDMAC_BIT_SIGNED = 3;
  localparam int MDMAC_BIT_OVF = 2;
  localparam int MDMAC_BIT_SIGNF = 1;
  localparam int MDMAC_BIT_START = 0;
  localparam logic [15:0] MDMAC_DATA_RESET = 16'h0000;
  localparam logic [7:0] MDMAC_CTRL_RESET = 8'h00;

  // ----------------------------------------
  // divider timing: one quotient bit per cycle
  // ----------------------------------------
  localparam int MDMAC_DIV_STEPS = 32;
  localparam logic [5:0] MDMAC_DIV_LAST = 6'h1F;

  // ----------------------------------------
  // operation modes decoded from the three mode bits
  // ----------------------------------------
  typedef enum logic [2:0] {
    MDMAC_MODE_MUL_U,
    MDMAC_MODE_MUL_S,
    MDMAC_MODE_MAC_U,
    MDMAC_MODE_MAC_S,
    MDMAC_MODE_DIV_IRQ,
    MDMAC_MODE_DIV_QUIET,
    MDMAC_MODE_BAD
  } mdmac_mode_type;

  // decode divide, accumulate and signed bits into a mode
  function automatic mdmac_mode_type mdmac_decode(input logic [2:0] sel);
    case (sel)
      3'h0: mdmac_decode = MDMAC_MODE_MUL_U;
      3'h1: mdmac_decode = MDMAC_MODE_MUL_S;
      3'h2: mdmac_decode = MDMAC_MODE_MAC_U;
      3'h3: mdmac_decode = MDMAC_MODE_MAC_S;
      3'h4: mdmac_decode = MDMAC_MODE_DIV_IRQ;
      3'h6: mdmac_decode = MDMAC_MODE_DIV_QUIET;
      default: mdmac_decode = MDMAC_MODE_BAD;
    endcase
  endfunction

endpackage

/* File: rtl/mdmac_mul.sv */
// 16x16 multiplier with signed/unsigned selection and registered product
`timescale 1ns/10ps
module mdmac_mul
  import mdmac_pkg::*;
(
  clk_sys,
  resetn,
  start,
  signed_mode,
  multiplier,
  multiplicand,
  product
);
  input wire logic clk_sys;
  input wire logic resetn;
  input wire logic start;
  input wire logic signed_mode;
  input wire logic [15:0] multiplier;
  input wire logic [15:0] multiplicand;
  output logic [31:0] product;

  typedef struct packed {
    logic [31:0] product;
  } mdmac_mul_state_type;

  mdmac_mul_state_type state_reg;
  mdmac_mul_state_type state_next;
  logic signed [33:0] full;

  // ----------------------------------------
  // product formation
  // ----------------------------------------
  // extend each operand by one bit so one signed multiplier serves both modes
  always_comb
  begin
    full = $signed({signed_mode & multiplier[15], multiplier})
         * $signed({signed_mode & multiplicand[15], multiplicand});
    state_next = state_reg;
    if (start)
    begin
      state_next.product = full[31:0];
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign product = state_reg.product;
endmodule

/* File: rtl/mdmac_div.sv */
// 32/32 unsigned restoring divider, one quotient bit per clock
`timescale 1ns/10ps
module mdmac_div
  import mdmac_pkg::*;
(
  clk_sys,
  resetn,
  start,
  dividend,
  divisor,
  done,
  quotient,
  remainder
);
  input wire logic clk_sys;
  input wire logic resetn;
  input wire logic start;
  input wire logic [31:0] dividend;
  input wire logic [31:0] divisor;
  output logic done;
  output logic [31:0] quotient;
  output logic [31:0] remainder;

  typedef struct packed {
    logic busy;
    logic done;
    logic [5:0] step;
    logic [31:0] quo;
    logic [31:0] rem;
    logic [31:0] dsr;
  } mdmac_div_state_type;

  mdmac_div_state_type state_reg;
  mdmac_div_state_type state_next;
  logic [32:0] trial;
  logic [32:0] shifted;

  // ----------------------------------------
  // iteration
  // ----------------------------------------
  // divisor is latched at start so later bus writes cannot corrupt it mid-way
  always_comb
  begin
    state_next = state_reg;
    state_next.done = 1'b0;
    shifted = {state_reg.rem, state_reg.quo[31]};
    trial = shifted - {1'b0, state_reg.dsr};
    if (start)
    begin
      state_next.busy = 1'b1;
      state_next.step = '0;
      state_next.quo = dividend;
      state_next.rem = '0;
      state_next.dsr = divisor;
    end
    else if (state_reg.busy)
    begin
      // zero divisor gives all-ones quotient; result is undefined anyway
      if (!trial[32])
      begin
        state_next.rem = trial[31:0];
      end
      else
      begin
        state_next.rem = shifted[31:0];
      end
      state_next.quo = {state_reg.quo[30:0], ~trial[32]};
      state_next.step = state_reg.step + 6'h01;
      if (state_reg.step == MDMAC_DIV_LAST)
      begin
        state_next.busy = 1'b0;
        state_next.done = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign done = state_reg.done;
  assign quotient = state_reg.quo;
  assign remainder = state_reg.rem;
endmodule

/* File: tb/mdmac_monitor.sv */
// port checker for the multiply/divide/accumulate unit
`timescale 1ns/10ps
module mdmac_monitor
  import mdmac_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic divide_done_irq,
  input wire logic mode_prohibited
);
  // ----------------------------------------
  // shadow of the mode bits and the divide countdown
  // ----------------------------------------
  logic [5:0] cnt_reg;
  logic irq_en_reg;
  logic [2:0] mode_reg;
  logic ctrl_wr;
  logic ctrl_rd;
  logic div_go;
  // control writes count only while no division runs
  assign ctrl_wr = reg_write && (reg_addr == MDMAC_ADDR_CTRL) && (cnt_reg == 6'h00);
  assign ctrl_rd = reg_read && (reg_addr == MDMAC_ADDR_CTRL);
  assign div_go = ctrl_wr && reg_wdata[MDMAC_BIT_DIV] && !reg_wdata[MDMAC_BIT_SIGNED]
    && reg_wdata[MDMAC_BIT_START];
  // result edge is 33 edges after the start write; count reaches 1 just before it
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_reg <= 6'h00;
      irq_en_reg <= 1'b0;
      mode_reg <= 3'h0;
    end
    else
    begin
      if (div_go)
        cnt_reg <= 6'h21;
      else if (cnt_reg != 6'h00)
        cnt_reg <= cnt_reg - 6'h01;
      if (div_go)
        irq_en_reg <= !reg_wdata[MDMAC_BIT_MAC];
      if (ctrl_wr)
        mode_reg <= {reg_wdata[MDMAC_BIT_DIV], reg_wdata[MDMAC_BIT_MAC],
          reg_wdata[MDMAC_BIT_SIGNED]};
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  property p_rdata_idle;
    !reg_read |=> reg_rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
  property p_irq_pulse;
    divide_done_irq |=> !divide_done_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("done pulse too long");
  property p_irq_time;
    cnt_reg == 6'h01 |=> divide_done_irq == irq_en_reg;
  endproperty
  a_irq_time: assert property (p_irq_time) else $error("done pulse missing");
  property p_irq_cause;
    divide_done_irq |-> $past(cnt_reg) == 6'h01;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("done pulse off time");
  property p_busy_read;
    ctrl_rd && cnt_reg > 6'h01 |=> reg_rdata[MDMAC_BIT_START];
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy bit low early");
  property p_idle_read;
    ctrl_rd && cnt_reg == 6'h00 |=> !reg_rdata[MDMAC_BIT_START];
  endproperty
  a_idle_read: assert property (p_idle_read) else $error("busy bit stuck");
  property p_mode_read;
    ctrl_rd |=> {reg_rdata[7:6], reg_rdata[3]} == mode_reg && reg_rdata[5:4] == 2'b00;
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode bits wrong");
  property p_prohib;
    mode_prohibited == (mode_reg[2] && mode_reg[0]);
  endproperty
  a_prohib: assert property (p_prohib) else $error("prohibited flag wrong");
endmodule

/* File: tb/mdmac_host.sv */
// host model driving the unit's register port as bus master
`timescale 1ns/10ps
module mdmac_host
  import mdmac_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [15:0] reg_rdata,
  output logic [3:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_write,
  output logic reg_read
);
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  // idle bus at time zero
  initial
  begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  // whole words only; released lines show the inverse so stale values never pass
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // answer taken in the single cycle it stands
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask
  task automatic wr32(input logic [3:0] a, input logic [31:0] v);
    wr(a + 4'h1, v[31:16]);
    wr(a, v[15:0]);
  endtask
  task automatic rd32(input logic [3:0] a, output logic [31:0] v);
    rd(a, v[15:0]);
    rd(a + 4'h1, v[31:16]);
  endtask
  // start, try to clear start, then poll only control until busy drops;
  // no data register is written or trusted meanwhile
  task automatic divide(input logic [7:0] code, output logic [1:0] busy);
    logic [15:0] s;
    int n;
    wr(MDMAC_ADDR_CTRL, {8'h00, code[7:1], 1'b1});
    wr(MDMAC_ADDR_CTRL, {8'h00, code[7:1], 1'b0});
    rd(MDMAC_ADDR_CTRL, s);
    busy[1] = s[0];
    n = 0;
    while (s[0] !== 1'b0 && n < 20)
    begin
      rd(MDMAC_ADDR_CTRL, s);
      n++;
    end
    busy[0] = s[0];
  endtask
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the multiply/divide/accumulate unit
`timescale 1ns/10ps
module tb_top;
  import mdmac_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [15:0] reg_rdata;
  logic divide_done_irq;
  logic mode_prohibited;
  logic ovf_exp = 1'b0;
  logic [31:0] b_exp = 32'h00000000;
  logic [7:0] codes [4] = '{8'h00, 8'h08, 8'h40, 8'h48};
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int irq_count = 0;
  // ----------------------------------------
  // clock, design, host and verdict
  // ----------------------------------------
  always #5 clk_sys = ~clk_sys;
  mdmac_unit mdmac_unit_i (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .divide_done_irq(divide_done_irq),
    .mode_prohibited(mode_prohibited));
  mdmac_host mdmac_host_i (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read));
  // hang guard far above the roughly fifteen hundred cycles the run needs
  always @(posedge clk_sys)
  begin
    cycles++;
    if (divide_done_irq === 1'b1)
      irq_count++;
    if (cycles == 30000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    if (n_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // low 32 bits of the product of sign- or zero-extended operands
  function automatic logic [31:0] prod(input logic [15:0] mr, input logic [15:0] mc,
    input logic sg);
    return {{16{sg & mr[15]}}, mr} * {{16{sg & mc[15]}}, mc};
  endfunction
  // unsigned carry or signed wrap of the accumulate step
  function automatic logic ovf(input logic [31:0] c, input logic [31:0] p, input logic sg);
    logic [32:0] s;
    s = {1'b0, c} + {1'b0, p};
    return sg ? (c[31] == p[31]) && (s[31] != c[31]) : s[32];
  endfunction
  // one multiply or accumulate step, operand halves in either order
  task automatic mac_op(input logic [7:0] code, input logic [15:0] mr, input logic [15:0] mc,
    input logic [31:0] cp);
    logic [31:0] v;
    logic [31:0] s;
    logic [15:0] w;
    b_exp = prod(mr, mc, code[3]);
    s = cp + b_exp;
    mdmac_host_i.wr(MDMAC_ADDR_CTRL, {8'h00, code});
    mdmac_host_i.wr32(MDMAC_ADDR_C_LOW, cp);
    if (mr[0])
      mdmac_host_i.wr(MDMAC_ADDR_A_HIGH, mr);
    mdmac_host_i.wr(MDMAC_ADDR_A_LOW, mc);
    if (!mr[0])
      mdmac_host_i.wr(MDMAC_ADDR_A_HIGH, mr);
    mdmac_host_i.rd32(MDMAC_ADDR_B_LOW, v);
    chk(v, b_exp);
    mdmac_host_i.rd32(MDMAC_ADDR_C_LOW, v);
    chk(v, code[6] ? s : cp);
    chk(mode_prohibited, 1'b0);
    if (code[6])
    begin
      ovf_exp = ovf_exp | ovf(cp, b_exp, code[3]);
      mdmac_host_i.rd(MDMAC_ADDR_CTRL, w);
      chk(w, {8'h00, code[7:3], ovf_exp, code[3] & s[31], 1'b0});
    end
  endtask
  // divide, divisor never zero
  task automatic div_op(input logic [7:0] code, input logic [31:0] dd, input logic [31:0] dv);
    logic [31:0] v;
    logic [1:0] busy;
    int n0;
    mdmac_host_i.wr(MDMAC_ADDR_CTRL, {8'h00, code});
    mdmac_host_i.wr32(MDMAC_ADDR_A_LOW, dd);
    mdmac_host_i.wr32(MDMAC_ADDR_B_LOW, dv);
    b_exp = dv;
    n0 = irq_count;
    mdmac_host_i.divide(code, busy);
    chk(busy, 2'b10);
    chk(irq_count - n0, !code[6]);
    mdmac_host_i.rd32(MDMAC_ADDR_A_LOW, v);
    chk(v, dd / dv);
    mdmac_host_i.rd32(MDMAC_ADDR_C_LOW, v);
    chk(v, dd % dv);
  endtask
  // all registers and one unmapped index read zero
  task automatic reset_check;
    logic [15:0] w;
    for (int a = 0; a < 8; a++)
    begin
      mdmac_host_i.rd(4'((a == 7) ? 15 : a), w);
      chk(w, 16'h0000);
    end
  endtask
  initial
  begin
    logic [15:0] w;
    logic [31:0] v;
    void'($urandom(32'h5745));
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    mdmac_host_i.wr(4'h9, 16'hFFFF);
    reset_check();
    mdmac_host_i.wr(MDMAC_ADDR_CTRL, 16'h0009);
    mdmac_host_i.rd(MDMAC_ADDR_CTRL, w);
    chk(w, 16'h0008);
    for (int m = 0; m < 4; m++)
    begin
      mac_op(codes[m], 16'hFFFF, 16'hFFFF, 32'hFFFFFFFF);
      mac_op(codes[m], 16'h8000, 16'h7FFF, 32'h80000000);
      repeat (6) mac_op(codes[m], 16'($urandom), 16'($urandom), $urandom);
    end
    for (int m = 0; m < 2; m++)
    begin
      div_op(m ? 8'hC0 : 8'h80, 32'hFFFFFFFF, 32'h00000001);
      div_op(m ? 8'hC0 : 8'h80, 32'h00000005, 32'hFFFFFFFF);
      repeat (4) div_op(m ? 8'hC0 : 8'h80, $urandom, ($urandom >> $urandom_range(31)) | 32'h1);
    end
    // prohibited codes must not start a multiply
    for (int m = 0; m < 2; m++)
    begin
      mdmac_host_i.wr(MDMAC_ADDR_CTRL, m ? 16'h00C8 : 16'h0088);
      mdmac_host_i.wr(MDMAC_ADDR_A_HIGH, 16'h1234);
      mdmac_host_i.wr(MDMAC_ADDR_A_LOW, 16'h5678);
      mdmac_host_i.rd32(MDMAC_ADDR_B_LOW, v);
      chk(v, b_exp);
      chk(mode_prohibited, 1'b1);
    end
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    reset_check();
    print_verdict();
  end
endmodule
bind mdmac_unit mdmac_monitor mdmac_monitor_i (.clk_sys(clk_sys), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .divide_done_irq(divide_done_irq), .mode_prohibited(mode_prohibited));
